// *** common/fan_pwm_pkg.sv ***
/*
  Shared definitions of the fan PWM configuration block: register indices,
  field layout, reset values, timing constants and the bus carrier types.
  Assumes a 125 MHz system clock and an AXI4-Lite register port.
*/
`default_nettype none

package fan_pwm_pkg;

  // Clocks
  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned TICK_HZ  = 3_200_000;
  // Fractional divider: step over wrap equals TICK_HZ over CLK_HZ
  localparam int unsigned TICK_GCD = 100_000;
  localparam logic [10:0] TICK_STEP = 11'(TICK_HZ / TICK_GCD);
  localparam logic [10:0] TICK_WRAP = 11'(CLK_HZ / TICK_GCD);

  // PWM rates per rate code, low range then high range
  localparam int unsigned HZ_LOW  [8] = '{10, 15, 23, 30, 38, 47, 62, 94};
  localparam int unsigned HZ_HIGH [8] = '{1000, 10000, 20000, 25000,
                                          30000, 40000, 40000, 40000};
  localparam int          PER_W       = 19;
  localparam int          PROD_W      = 27;

  // Spin-up times per code, in milliseconds, counted in units
  localparam int unsigned SPIN_MS [8] = '{200, 400, 600, 800, 1000, 2000, 4000, 8000};
  localparam int unsigned SPIN_UNIT_MS   = 200;
  localparam int unsigned SPIN_UNIT_CLKS = SPIN_UNIT_MS * (CLK_HZ / 1000);

  // Register indices; byte address is four times the index
  localparam int          ADDR_W   = 12;
  localparam logic [9:0]  IDX_CHAR = 10'h020;
  localparam logic [9:0]  IDX_DUTY = 10'h022;
  localparam logic [9:0]  IDX_MODE = 10'h030;

  // Reset values
  localparam logic [7:0]  CHAR_RST = 8'h1D;
  localparam logic [7:0]  DUTY_RST = 8'h55;
  localparam logic [1:0]  MODE_RST = 2'h1;

  // Field positions
  localparam int          SPIN_DIS_BIT = 7;
  localparam int          RATE_LSB     = 3;
  localparam int          SPIN_LSB     = 0;
  localparam int          MODE_LSB     = 0;
  localparam int          TACH_BIT     = 2;
  localparam int          SPIN_ACT_BIT = 7;
  localparam logic [7:0]  CHAR_WMASK   = 8'hBF;

  // Duty codes
  localparam logic [7:0]  DUTY_OFF     = 8'h00;
  localparam logic [7:0]  DUTY_FULL    = 8'hFF;
  localparam logic [7:0]  DUTY_MIN_RPM = 8'h4D;
  localparam logic [7:0]  DUTY_MIN_ON  = 8'h12;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_AUTO_TEMP = 2'b00,
    MODE_SW_DUTY   = 2'b01,
    MODE_SW_RPM    = 2'b10
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CHAR = 2'b01,
    SEL_DUTY = 2'b10,
    SEL_MODE = 2'b11
  } reg_sel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } axil_rsp_t;

endpackage

`default_nettype wire

// *** verification/fan_model.sv ***
/*
  Fan motor model: watches the PWM drive and reports the length of the
  last complete period in clk cycles. Assumes the drive is synchronous to clk.
*/
`default_nettype none

module fan_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Drive from the controller
  input  wire logic pwm,
  // Last full period
  output var int    period
);
  timeunit 1ns;
  timeprecision 1ps;

  int   cnt;
  logic prev;

  // Period from rising edge to rising edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt    <= 0;
      prev   <= 1'b0;
      period <= 0;
    end else begin
      prev <= pwm;
      if (pwm && !prev) begin
        period <= cnt;
        cnt    <= 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

`default_nettype wire

// *** verification/test_fan_pwm_duty_and_rate_config.sv ***
/*
  Testbench of the fan PWM configuration block: AXI4-Lite register
  sequences with expected values, duty and period measured at the pin.
  Assumes a short spin-up unit and the kHz range strap.
*/
`default_nettype none

module test_fan_pwm_duty_and_rate_config;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int          UNIT   = 20;
  localparam logic [11:0] A_CHAR = 12'h080;
  localparam logic [11:0] A_DUTY = 12'h088;
  localparam logic [11:0] A_MODE = 12'h0C0;

  logic                    clk;
  logic                    reset;
  fan_pwm_pkg::axil_req_t  req;
  fan_pwm_pkg::axil_rsp_t  rsp;
  logic                    range_pin;
  logic [7:0]              loop_duty;
  logic                    pwm_out;
  int                      period;
  int                      n_errors;
  int                      total_checks;
  logic [31:0]             rd_v;
  logic [1:0]              rs_v;
  int                      c;

  fan_pwm_ctrl #(.SPIN_UNIT_CLKS(UNIT)) dut_u (
    .clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
    .pwm_range_pin(range_pin), .loop_duty(loop_duty), .pwm_out(pwm_out));
  fan_model fan_u (.clk(clk), .reset(reset), .pwm(pwm_out), .period(period));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("errors %0d of %0d checks", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic near(input int s, input int e, input int t);
    chk((s >= e - t && s <= e + t) ? 32'(e) : 32'(s), 32'(e));
  endtask

  task automatic tmo(input int n);
    if (n == 2000) begin
      n_errors++;
      finish_test();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int   n;
    logic ta;
    logic tw;
    logic tb;
    req.awaddr  <= a;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (!(req.awvalid || req.wvalid || req.bready)) break;
      ta = req.awvalid && rsp.awready === 1'b1;
      tw = req.wvalid && rsp.wready === 1'b1;
      tb = !req.awvalid && !req.wvalid && rsp.bvalid === 1'b1;
      if (tb) rs_v = rsp.bresp;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) req.bready <= 1'b0;
    end
    tmo(n);
  endtask

  task automatic rd(input logic [11:0] a);
    int   n;
    logic ta;
    logic tr;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (n = 0; n < 2000; n++) begin
      @(negedge clk);
      if (!(req.arvalid || req.rready)) break;
      ta = req.arvalid && rsp.arready === 1'b1;
      tr = !req.arvalid && rsp.rvalid === 1'b1;
      if (tr) {rs_v, rd_v} = {rsp.rresp, rsp.rdata};
      @(posedge clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr) req.rready <= 1'b0;
    end
    tmo(n);
  endtask

  // High cycles of the pin over a window
  task automatic hrun(input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += int'(pwm_out);
    end
    @(posedge clk);
  endtask

  // Loop duty, duty write, mode, then pin duty and read-back
  task automatic step(input logic [7:0] m, input logic [7:0] l, input logic [7:0] w,
                      input logic [7:0] ep, input logic [7:0] er);
    loop_duty <= l;
    wr(A_DUTY, w);
    wr(A_MODE, m);
    repeat (3200) @(posedge clk);
    hrun(3125);
    if (ep == 8'h00 || ep == 8'hFF) begin
      chk(32'(c), (ep == 8'hFF) ? 32'h0C35 : 32'h0);
    end else begin
      near((c * 255 + 1562) / 3125, int'(ep), 4);
    end
    rd(A_DUTY);
    chk(rd_v, {24'h000000, er});
  endtask

  task automatic freq(input logic [2:0] code, input int khz);
    wr(A_CHAR, {2'b10, code, 3'b111});
    repeat (2 * (125000 / khz) + 200) @(posedge clk);
    near(period, 125000 / khz, 45);
  endtask

  initial begin
    reset     = 1'b1;
    req       = '0;
    range_pin = 1'b0;
    loop_duty = 8'h00;
    n_errors  = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // Pin is driven full from the second edge after release
    repeat (2) @(posedge clk);
    hrun(190);
    chk(32'(c), 32'h0BE);
    rd(A_MODE);
    chk(rd_v, 32'h81);
    rd(A_CHAR);
    chk(rd_v, 32'h1D);
    rd(A_DUTY);
    chk(rd_v, 32'h55);
    wr(A_CHAR, 8'hFF);
    chk({30'h0, rs_v}, 32'h0);
    rd(A_CHAR);
    chk(rd_v, 32'hBF);
    rd(12'h100);
    chk({30'h0, rs_v}, 32'h2);
    wr(12'h100, 8'h00);
    chk({30'h0, rs_v}, 32'h2);
    // Spin-up of 800 cycles, then with spin-up disabled
    wr(A_CHAR, 8'h2F);
    wr(A_DUTY, 8'h00);
    repeat (3200) @(posedge clk);
    wr(A_DUTY, 8'h13);
    @(posedge clk);
    hrun(700);
    chk(32'(c), 32'h2BC);
    wr(A_CHAR, 8'hAF);
    wr(A_DUTY, 8'h00);
    repeat (3200) @(posedge clk);
    wr(A_DUTY, 8'h13);
    @(posedge clk);
    hrun(700);
    chk(32'(c < 250), 32'h1);
    step(8'h01, 8'h00, 8'h40, 8'h40, 8'h40);
    step(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
    step(8'h01, 8'h00, 8'hFF, 8'hFF, 8'hFF);
    step(8'h02, 8'h10, 8'hC0, 8'h4D, 8'h10);
    step(8'h06, 8'h10, 8'hC0, 8'h10, 8'h10);
    step(8'h00, 8'h11, 8'hC0, 8'h00, 8'h11);
    step(8'h03, 8'h11, 8'hC0, 8'h00, 8'h11);
    step(8'h00, 8'h12, 8'hC0, 8'h12, 8'h12);
    step(8'h01, 8'h12, 8'hC0, 8'hC0, 8'hC0);
    freq(3'h3, 25);
    freq(3'h4, 30);
    freq(3'h7, 40);
    finish_test();
  end
endmodule

`default_nettype wire

// *** verilog/fan_axil_slave.sv ***
/*
  AXI4-Lite slave front end: takes write address and data in either order,
  answers each write and read, and hands byte lane 0 to the register file.
  Assumes the register file decodes addresses and reports hits.
*/
`default_nettype none

module fan_axil_slave (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // Bus
  input  wire fan_pwm_pkg::axil_req_t         axi_req,
  output fan_pwm_pkg::axil_rsp_t              axi_rsp,
  // Register file side
  output logic                                wr_en,
  output logic [fan_pwm_pkg::ADDR_W-1:0]      wr_addr,
  output logic [7:0]                          wr_data,
  input  wire logic                           wr_ok,
  output logic [fan_pwm_pkg::ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]                    rd_data,
  input  wire logic                           rd_ok
);

  logic        aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic        arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [3:0]  wstrb_q;
  logic [31:0] wdata_q, rdata_q;
  logic        wr_go;

  assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_en   = wr_go & wstrb_q[0];
  assign wr_data = wdata_q[7:0];
  assign rd_addr = axi_req.araddr;

  always_comb begin
    axi_rsp.awready = awready_q;
    axi_rsp.wready  = wready_q;
    axi_rsp.bresp   = bresp_q;
    axi_rsp.bvalid  = bvalid_q;
    axi_rsp.arready = arready_q;
    axi_rsp.rdata   = rdata_q;
    axi_rsp.rresp   = rresp_q;
    axi_rsp.rvalid  = rvalid_q;
  end

  // Write channels and response
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      wr_addr   <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (axi_req.awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        wr_addr   <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? fan_pwm_pkg::RESP_OKAY : fan_pwm_pkg::RESP_SLVERR;
      end else if (bvalid_q && axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end else if (axi_req.arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_ok ? fan_pwm_pkg::RESP_OKAY : fan_pwm_pkg::RESP_SLVERR;
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** verilog/fan_pwm_ctrl.sv ***
/*
  Fan PWM duty and rate configuration: duty code register with shadow
  behaviour, clamping by control mode, characteristics register with rate
  and spin-up selection, spin-up timer, and the AXI4-Lite register port.
  Assumes the range pin and the loop duty are synchronous to clk.
*/
// Function
// - Duty code maps linearly: 0x00 is 0%, 0xFF is 100%.
// - Duty code register resets to 0x55.
// - Duty read returns the duty driving the pin, except clamp cases; during spin-up the read gives the computed code, not 0xFF.
// - Tach_sense_mode 0, speed mode: duty below 30% driven at 30%, read uncorrected.
// - Tach_sense_mode 0, duty or auto mode: below 7% driven 0%, read uncorrected.
// - In software duty mode a written code drives the output at once.
// - Other modes: written code is shadowed, takes over on switch to duty mode.
// - Range pin high: rate codes give 10 to 94 Hz, reset code 011.
// - During spin-up the output runs at 100% duty.
// - Spin-up disable bit set skips spin-up; resets to 0.
// - PWM periods come from a 3.2 MHz timing tick.
`default_nettype none

module fan_pwm_ctrl #(
  parameter int unsigned SPIN_UNIT_CLKS = fan_pwm_pkg::SPIN_UNIT_CLKS
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Register bus
  input  wire fan_pwm_pkg::axil_req_t axi_req,
  output fan_pwm_pkg::axil_rsp_t      axi_rsp,
  // Range strap, low selects the kHz range
  input  wire logic                   pwm_range_pin,
  // Duty computed by the temperature or speed loop
  input  wire logic [7:0]             loop_duty,
  // Fan drive
  output logic                        pwm_out
);

  localparam int AW = fan_pwm_pkg::ADDR_W;

  // Register file
  logic [7:0]  char_q;
  logic [7:0]  duty_code_q;
  logic [1:0]  mode_q;
  logic        tach_q;

  // Bus side
  logic          wr_en, wr_ok, rd_ok;
  logic [AW-1:0] wr_addr, rd_addr;
  logic [7:0]    wr_data;
  logic [31:0]   rd_data;
  fan_pwm_pkg::reg_sel_t wr_sel, rd_sel;

  // Duty path
  logic [7:0]  comp_duty;
  logic [7:0]  clamp_duty;
  logic [7:0]  pin_duty_q;
  logic        range_high_q;
  logic        tach_zero;

  // Spin-up
  logic        spin_q, prev_zero_q, spin_start, pin_zero, spin_dis;
  logic [31:0] unit_cnt_q;
  logic [7:0]  units_q;
  logic [7:0]  spin_units [8];
  logic [7:0]  spin_target;

  function automatic fan_pwm_pkg::reg_sel_t reg_decode(input logic [AW-1:0] addr);
    logic [9:0] idx;
    idx = addr[AW-1:2];
    case (idx)
      fan_pwm_pkg::IDX_CHAR: reg_decode = fan_pwm_pkg::SEL_CHAR;
      fan_pwm_pkg::IDX_DUTY: reg_decode = fan_pwm_pkg::SEL_DUTY;
      fan_pwm_pkg::IDX_MODE: reg_decode = fan_pwm_pkg::SEL_MODE;
      default:               reg_decode = fan_pwm_pkg::SEL_NONE;
    endcase
  endfunction

  fan_axil_slave u_slave (
    .clk     (clk),
    .reset   (reset),
    .axi_req (axi_req),
    .axi_rsp (axi_rsp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  assign wr_sel = reg_decode(wr_addr);
  assign rd_sel = reg_decode(rd_addr);
  assign wr_ok  = wr_sel != fan_pwm_pkg::SEL_NONE;
  assign rd_ok  = rd_sel != fan_pwm_pkg::SEL_NONE;

  // Characteristics register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      char_q <= fan_pwm_pkg::CHAR_RST;
    end else if (wr_en && wr_sel == fan_pwm_pkg::SEL_CHAR) begin
      char_q <= wr_data & fan_pwm_pkg::CHAR_WMASK;
    end
  end

  // Duty code, also the shadow outside software duty mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      duty_code_q <= fan_pwm_pkg::DUTY_RST;
    end else if (wr_en && wr_sel == fan_pwm_pkg::SEL_DUTY) begin
      duty_code_q <= wr_data;
    end
  end

  // Control mode and tach sense mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_q <= fan_pwm_pkg::MODE_RST;
      tach_q <= 1'b0;
    end else if (wr_en && wr_sel == fan_pwm_pkg::SEL_MODE) begin
      mode_q <= wr_data[fan_pwm_pkg::MODE_LSB +: 2];
      tach_q <= wr_data[fan_pwm_pkg::TACH_BIT];
    end
  end

  // Computed duty: register in software duty mode, loop otherwise
  assign comp_duty = (mode_q == fan_pwm_pkg::MODE_SW_DUTY) ? duty_code_q
                                                           : loop_duty;
  assign tach_zero = ~tach_q;

  always_comb begin
    clamp_duty = comp_duty;
    if (tach_zero && mode_q == fan_pwm_pkg::MODE_SW_RPM &&
        comp_duty < fan_pwm_pkg::DUTY_MIN_RPM) begin
      clamp_duty = fan_pwm_pkg::DUTY_MIN_RPM;
    end else if (tach_zero && mode_q != fan_pwm_pkg::MODE_SW_RPM &&
                 comp_duty < fan_pwm_pkg::DUTY_MIN_ON) begin
      clamp_duty = fan_pwm_pkg::DUTY_OFF;
    end
  end

  // Read data: the computed code equals the pin code outside clamping and spin-up
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_sel)
      fan_pwm_pkg::SEL_CHAR: rd_data[7:0] = char_q;
      fan_pwm_pkg::SEL_DUTY: rd_data[7:0] = comp_duty;
      fan_pwm_pkg::SEL_MODE: begin
        rd_data[fan_pwm_pkg::MODE_LSB +: 2]    = mode_q;
        rd_data[fan_pwm_pkg::TACH_BIT]        = tach_q;
        rd_data[fan_pwm_pkg::SPIN_ACT_BIT]    = spin_q;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Spin-up length table in timer units
  for (genvar g = 0; g < 8; g++) begin : g_spin
    assign spin_units[g] = 8'(fan_pwm_pkg::SPIN_MS[g] / fan_pwm_pkg::SPIN_UNIT_MS);
  end

  assign spin_target = spin_units[char_q[fan_pwm_pkg::SPIN_LSB +: 3]];
  assign spin_dis    = char_q[fan_pwm_pkg::SPIN_DIS_BIT];
  assign pin_zero    = clamp_duty == fan_pwm_pkg::DUTY_OFF;
  assign spin_start  = prev_zero_q & ~pin_zero & ~spin_dis;

  // Fan start detection: output leaving zero duty
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_zero_q <= 1'b1;
    end else begin
      prev_zero_q <= pin_zero;
    end
  end

  // Spin-up timer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spin_q     <= 1'b0;
      unit_cnt_q <= 32'h0000_0000;
      units_q    <= 8'h00;
    end else if (spin_dis || pin_zero) begin
      spin_q <= 1'b0;
    end else if (spin_start) begin
      spin_q     <= 1'b1;
      unit_cnt_q <= 32'h0000_0000;
      units_q    <= 8'h00;
    end else if (spin_q) begin
      if (unit_cnt_q == SPIN_UNIT_CLKS - 1) begin
        unit_cnt_q <= 32'h0000_0000;
        // A shorter code written mid-run ends the spin-up at the end of the first unit that reaches its length, the current one if already past
        if (units_q >= spin_target - 8'h01) begin
          spin_q <= 1'b0;
        end else begin
          units_q <= units_q + 8'h01;
        end
      end else begin
        unit_cnt_q <= unit_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Duty at the pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_duty_q <= fan_pwm_pkg::DUTY_OFF;
    end else begin
      pin_duty_q <= spin_q ? fan_pwm_pkg::DUTY_FULL : clamp_duty;
    end
  end

  // Range strap, low selects the kHz range
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      range_high_q <= 1'b0;
    end else begin
      range_high_q <= ~pwm_range_pin;
    end
  end

  fan_pwm_wave u_wave (
    .clk        (clk),
    .reset      (reset),
    .range_high (range_high_q),
    .rate_sel   (char_q[fan_pwm_pkg::RATE_LSB +: 3]),
    .duty       (pin_duty_q),
    .pwm_q      (pwm_out)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_duty_write;
    wr_en && wr_sel == fan_pwm_pkg::SEL_DUTY;
  endsequence

  sequence s_sw_duty;
    mode_q == fan_pwm_pkg::MODE_SW_DUTY;
  endsequence

  property p_duty_reset;
    $fell(reset) |-> duty_code_q == fan_pwm_pkg::DUTY_RST;
  endproperty
  a_duty_reset: assert property (p_duty_reset) else $error("duty code reset wrong");

  property p_sw_write;
    s_sw_duty ##0 s_duty_write ##1 s_sw_duty |-> comp_duty == $past(wr_data);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("written duty not applied");

  property p_shadow;
    !(mode_q == fan_pwm_pkg::MODE_SW_DUTY) |-> comp_duty == loop_duty;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow drove output");

  property p_rpm_clamp;
    tach_zero && mode_q == fan_pwm_pkg::MODE_SW_RPM && comp_duty < fan_pwm_pkg::DUTY_MIN_RPM
      && !spin_q |=> pin_duty_q == fan_pwm_pkg::DUTY_MIN_RPM;
  endproperty
  a_rpm_clamp: assert property (p_rpm_clamp) else $error("speed mode clamp wrong");

  property p_low_cut;
    tach_zero && mode_q != fan_pwm_pkg::MODE_SW_RPM && comp_duty < fan_pwm_pkg::DUTY_MIN_ON
      && !spin_q |=> pin_duty_q == fan_pwm_pkg::DUTY_OFF;
  endproperty
  a_low_cut: assert property (p_low_cut) else $error("low duty not cut");

  property p_read_duty;
    rd_sel == fan_pwm_pkg::SEL_DUTY |-> rd_data[7:0] == comp_duty;
  endproperty
  a_read_duty: assert property (p_read_duty) else $error("duty read mismatch");

  property p_spin_full;
    spin_q |=> pin_duty_q == fan_pwm_pkg::DUTY_FULL;
  endproperty
  a_spin_full: assert property (p_spin_full) else $error("spin-up not full duty");

  property p_spin_dis;
    spin_dis |=> !spin_q;
  endproperty
  a_spin_dis: assert property (p_spin_dis) else $error("spin-up while disabled");

  property p_spin_start;
    spin_start |=> spin_q && units_q == 8'h00;
  endproperty
  a_spin_start: assert property (p_spin_start) else $error("spin-up did not start");

  property p_rsvd_zero;
    char_q[6] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_char_reset;
    $fell(reset) |-> char_q == fan_pwm_pkg::CHAR_RST;
  endproperty
  a_char_reset: assert property (p_char_reset) else $error("char reset wrong");

  property p_spin_end;
    spin_q && !spin_dis && !pin_zero && unit_cnt_q == SPIN_UNIT_CLKS - 1
      && units_q >= spin_target - 8'h01 |=> !spin_q;
  endproperty
  a_spin_end: assert property (p_spin_end) else $error("spin-up overran");

endmodule

`default_nettype wire

// *** verilog/fan_pwm_wave.sv ***
/*
  PWM waveform generator: 3.2 MHz timing tick from a fractional divider,
  period chosen by range and rate code, duty compared as code over 255.
  Assumes duty and rate inputs are synchronous to clk.
*/
`default_nettype none

module fan_pwm_wave (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Rate and duty
  input  wire logic       range_high,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] duty,
  // Output
  output logic            pwm_q
);

  localparam int PW = fan_pwm_pkg::PER_W;
  localparam int XW = fan_pwm_pkg::PROD_W;

  logic [10:0]   acc_q;
  logic [11:0]   acc_sum;
  logic          tick_q;
  logic [PW-1:0] cnt_q, period;
  logic [PW-1:0] per_low  [8];
  logic [PW-1:0] per_high [8];
  logic [XW-1:0] cnt_scaled, duty_scaled;

  // Period tables in timing ticks
  for (genvar g = 0; g < 8; g++) begin : g_per
    assign per_low[g]  = PW'(fan_pwm_pkg::TICK_HZ / fan_pwm_pkg::HZ_LOW[g]);
    assign per_high[g] = PW'(fan_pwm_pkg::TICK_HZ / fan_pwm_pkg::HZ_HIGH[g]);
  end

  assign period  = range_high ? per_high[rate_sel] : per_low[rate_sel];
  assign acc_sum = {1'b0, acc_q} + {1'b0, fan_pwm_pkg::TICK_STEP};

  // Average 3.2 MHz tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_q  <= 11'h000;
      tick_q <= 1'b0;
    end else if (acc_sum >= {1'b0, fan_pwm_pkg::TICK_WRAP}) begin
      acc_q  <= 11'(acc_sum - {1'b0, fan_pwm_pkg::TICK_WRAP});
      tick_q <= 1'b1;
    end else begin
      acc_q  <= acc_sum[10:0];
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (tick_q) begin
      cnt_q <= (cnt_q >= period - PW'(1)) ? '0 : cnt_q + PW'(1);
    end
  end

  // High while cnt*255 < duty*period
  assign cnt_scaled  = XW'(cnt_q) * XW'(255);
  assign duty_scaled = XW'(duty) * XW'(period);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_q <= 1'b0;
    end else begin
      // Full code stays high even while the count overruns a shortened period
      pwm_q <= (duty == fan_pwm_pkg::DUTY_FULL) || (cnt_scaled < duty_scaled);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_tick_spacing;
    tick_q |=> !tick_q [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

  property p_duty_full;
    (duty == fan_pwm_pkg::DUTY_FULL) [*2] |-> pwm_q;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty not high");

  property p_duty_zero;
    (duty == fan_pwm_pkg::DUTY_OFF) [*2] |-> !pwm_q;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty not low");

endmodule

`default_nettype wire
